// File: core/flash_seq_defines.svh
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define CLK_MHZ 50

`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK32_ERASE 8'h52
`define OP_BLOCK64_ERASE 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_POWERDOWN 8'hb9
`define OP_RELEASE 8'hab

`define LEN_OPCODE 6'h08
`define LEN_OPADDR 6'h20
`define LEN_MAX 6'h3f

`define SR1_BUSY_BIT 0
`define SR1_WEL_BIT 1
`define SR2_SUS_BIT 7

`define ARRAY_TOP 21'h100000
`define MASK_SECTOR 20'h00fff
`define MASK_BLOCK32 20'h07fff
`define MASK_BLOCK64 20'h0ffff
`define MASK_CHIP 20'hfffff
`define PROT_SHIFT_SECTOR 5'h0c
`define PROT_SHIFT_BLOCK 5'h10
`define PROT_SHIFT_ALL 5'h14

`define SECTOR_ERASE_TIME_US 45000
`define BLOCK32_ERASE_TIME_US 120000
`define BLOCK64_ERASE_TIME_US 150000
`define CHIP_ERASE_TIME_US 2000000
`define SUSPEND_TIME_US 20
`define POWERDOWN_ENTRY_TIME_US 3
`define POWERDOWN_RELEASE_TIME_US 3

`define SECTOR_ERASE_CYC (`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`define BLOCK32_ERASE_CYC (`BLOCK32_ERASE_TIME_US * `CLK_MHZ)
`define BLOCK64_ERASE_CYC (`BLOCK64_ERASE_TIME_US * `CLK_MHZ)
`define CHIP_ERASE_CYC (`CHIP_ERASE_TIME_US * `CLK_MHZ)
`define SUSPEND_CYC (`SUSPEND_TIME_US * `CLK_MHZ)
`define POWERDOWN_ENTRY_CYC (`POWERDOWN_ENTRY_TIME_US * `CLK_MHZ)
`define POWERDOWN_RELEASE_CYC (`POWERDOWN_RELEASE_TIME_US * `CLK_MHZ)

`endif

// File: core/flash_seq_pkg.sv
package flash_seq_pkg;

    typedef enum logic [1:0] {
        ER_IDLE = 2'b00,
        ER_RUN = 2'b01,
        ER_SUSPENDING = 2'b10,
        ER_SUSPENDED = 2'b11
    } erase_state_t;

    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_ENTER = 2'b01,
        PM_DOWN = 2'b10,
        PM_EXIT = 2'b11
    } power_state_t;

    typedef enum logic [1:0] {
        EK_SECTOR = 2'b00,
        EK_BLOCK32 = 2'b01,
        EK_BLOCK64 = 2'b10,
        EK_CHIP = 2'b11
    } erase_kind_t;

    typedef struct packed {
        logic protect_complement;
        logic protect_granularity_select;
        logic protect_top_bottom;
        logic protect_level_bit2;
        logic protect_level_bit1;
        logic protect_level_bit0;
    } protect_t;

    typedef struct packed {
        erase_kind_t kind;
        logic [19:0] first;
        logic [19:0] last;
    } erase_region_t;

    typedef struct packed {
        logic busy;
        logic write_enable_latch;
        logic suspend_flag;
        logic powerdown;
    } status_t;

endpackage

// File: core/sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // The first stage feeds only the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

`default_nettype wire

// File: core/flash_erase_seq.sv
`include "flash_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_erase_seq #(
    parameter int unsigned SECTOR_ERASE_CYC = `SECTOR_ERASE_CYC,
    parameter int unsigned BLOCK32_ERASE_CYC = `BLOCK32_ERASE_CYC,
    parameter int unsigned BLOCK64_ERASE_CYC = `BLOCK64_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYC = `CHIP_ERASE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_di_i,
    output logic spi_do_o,
    output logic spi_do_oe_o,
    input wire flash_seq_pkg::protect_t protect_i,
    output flash_seq_pkg::status_t status_o,
    output flash_seq_pkg::erase_region_t region_o,
    output logic erase_active_o,
    output logic erase_done_o,
    output logic cmd_refused_o
);
    import flash_seq_pkg::*;

    // Link side, clocked by the serial clock
    logic in_frame_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] shift_reg;
    logic [7:0] out_reg;
    logic out_en_reg;
    status_t stat_link;
    status_t stat_core;
    logic [7:0] link_opcode;
    logic [7:0] sr1_byte;
    logic [7:0] sr2_byte;

    // Core side, clocked by mclk_i
    logic cs_n_sync;
    logic cs_n_prev_reg;
    logic frame_end;
    logic len_op;
    logic len_opaddr;
    logic [7:0] opcode;
    logic [19:0] addr;
    logic is_erase;
    erase_kind_t kind;
    logic [19:0] mask;
    logic [19:0] first;
    logic [19:0] last;
    logic prot_hit;
    logic [31:0] erase_cyc;

    erase_state_t er_reg;
    power_state_t pm_reg;
    logic [31:0] remain_reg;
    logic [15:0] sus_cnt_reg;
    logic [15:0] pm_cnt_reg;
    logic wel_reg;
    logic sus_reg;
    logic busy;
    logic take;
    logic acc_wren;
    logic acc_wrdi;
    logic acc_erase;
    logic acc_susp;
    logic acc_res;
    logic acc_pd;
    logic acc_rel;

    // A frame starts at its first clock edge; chip select clears it at once
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            in_frame_reg <= 1'b0;
        end else begin
            in_frame_reg <= 1'b1;
        end
    end

    // Bits enter MSB first on rising edges; the count saturates so long frames never alias
    always_ff @(posedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= 32'h0000_0000;
            bit_cnt_reg <= 6'h00;
        end else begin
            shift_reg <= {shift_reg[30:0], spi_di_i};
            if (!in_frame_reg) begin
                bit_cnt_reg <= 6'h01;
            end else if (bit_cnt_reg != `LEN_MAX) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
        end
    end

    // Status seen by the link; the serial clock runs during the opcode, which fills the sync
    sync2 #(.W(4), .RST_VAL(4'h0)) u_sync_stat (
        .clk_i(spi_clk_i),
        .rst_i(rst_i),
        .d_i(stat_core),
        .q_o(stat_link)
    );

    assign link_opcode = shift_reg[7:0];

    always_comb begin
        sr1_byte = 8'h00;
        sr1_byte[`SR1_BUSY_BIT] = stat_link.busy;
        sr1_byte[`SR1_WEL_BIT] = stat_link.write_enable_latch;
        sr2_byte = 8'h00;
        sr2_byte[`SR2_SUS_BIT] = stat_link.suspend_flag;
    end

    // Status bytes go out on falling edges and repeat until chip select rises
    always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            out_reg <= 8'h00;
            out_en_reg <= 1'b0;
        end else if (bit_cnt_reg == `LEN_OPCODE && !stat_link.powerdown
                     && link_opcode == `OP_RDSR1) begin
            out_reg <= sr1_byte;
            out_en_reg <= 1'b1;
        end else if (bit_cnt_reg == `LEN_OPCODE && !stat_link.powerdown
                     && link_opcode == `OP_RDSR2) begin
            out_reg <= sr2_byte;
            out_en_reg <= 1'b1;
        end else begin
            out_reg <= {out_reg[6:0], out_reg[7]};
        end
    end

    // Reads are silent in power-down because the load above never fires there
    assign spi_do_o = out_reg[7];
    assign spi_do_oe_o = out_en_reg & ~spi_cs_n_i;

    // Chip select crossing; frame words are read once it is high, when the
    // serial clock is still, so they are stable for the core
    sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_cs (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(spi_cs_n_i),
        .q_o(cs_n_sync)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_n_prev_reg <= 1'b1;
        end else begin
            cs_n_prev_reg <= cs_n_sync;
        end
    end

    assign frame_end = cs_n_sync & ~cs_n_prev_reg;
    // Only exact lengths count, so a late or early rise drops the command
    assign len_op = (bit_cnt_reg == `LEN_OPCODE);
    assign len_opaddr = (bit_cnt_reg == `LEN_OPADDR);
    assign opcode = len_opaddr ? shift_reg[31:24] : shift_reg[7:0];
    assign addr = shift_reg[19:0];

    function automatic logic in_prot(input logic [19:0] a, input protect_t p);
        logic [2:0] lvl;
        logic [4:0] sh;
        logic [20:0] span;
        logic hit;
        lvl = {p.protect_level_bit2, p.protect_level_bit1, p.protect_level_bit0};
        sh = (p.protect_granularity_select ? `PROT_SHIFT_SECTOR : `PROT_SHIFT_BLOCK)
             + {2'b00, lvl} - 5'h01;
        span = 21'h000001 << sh;
        if (lvl == 3'h0) begin
            hit = 1'b0;
        end else if (sh >= `PROT_SHIFT_ALL) begin
            hit = 1'b1;
        end else if (p.protect_top_bottom) begin
            hit = {1'b0, a} < span;
        end else begin
            hit = {1'b0, a} >= (`ARRAY_TOP - span);
        end
        return hit ^ p.protect_complement;
    endfunction

    always_comb begin
        is_erase = 1'b0;
        kind = EK_SECTOR;
        mask = `MASK_SECTOR;
        erase_cyc = SECTOR_ERASE_CYC;
        unique case (opcode)
            `OP_SECTOR_ERASE: begin
                is_erase = len_opaddr;
            end
            `OP_BLOCK32_ERASE: begin
                is_erase = len_opaddr;
                kind = EK_BLOCK32;
                mask = `MASK_BLOCK32;
                erase_cyc = BLOCK32_ERASE_CYC;
            end
            `OP_BLOCK64_ERASE: begin
                is_erase = len_opaddr;
                kind = EK_BLOCK64;
                mask = `MASK_BLOCK64;
                erase_cyc = BLOCK64_ERASE_CYC;
            end
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
                is_erase = len_op;
                kind = EK_CHIP;
                mask = `MASK_CHIP;
                erase_cyc = CHIP_ERASE_CYC;
            end
            default: begin
                is_erase = 1'b0; // Program opcodes have no job here and drop
            end
        endcase
    end

    assign first = addr & ~mask;
    assign last = addr | mask;
    // The protected span sits at one end of the array, so testing both ends
    // of an aligned region finds any overlap; a chip region covers it all
    assign prot_hit = in_prot(first, protect_i) | in_prot(last, protect_i);

    assign busy = (er_reg == ER_RUN) || (er_reg == ER_SUSPENDING);
    assign take = frame_end && (pm_reg == PM_NORMAL);
    assign acc_wren = take && len_op && opcode == `OP_WREN && !busy;
    assign acc_wrdi = take && len_op && opcode == `OP_WRDI && !busy;
    // Erases are refused while busy or while another erase is parked
    assign acc_erase = take && is_erase && wel_reg && !busy
                       && er_reg != ER_SUSPENDED;
    assign acc_susp = take && len_op && opcode == `OP_SUSPEND && !sus_reg
                      && er_reg == ER_RUN
                      && region_o.kind != EK_CHIP;
    assign acc_res = take && len_op && opcode == `OP_RESUME && sus_reg
                     && er_reg == ER_SUSPENDED;
    assign acc_pd = take && len_op && opcode == `OP_POWERDOWN && !busy;
    assign acc_rel = frame_end && pm_reg == PM_DOWN && len_op
                     && opcode == `OP_RELEASE;

    // Erase sequencing; the remaining time is frozen while suspended
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            er_reg <= ER_IDLE;
            remain_reg <= 32'h0000_0000;
            sus_cnt_reg <= 16'h0000;
            region_o <= '0;
            erase_done_o <= 1'b0;
            cmd_refused_o <= 1'b0;
        end else begin
            erase_done_o <= 1'b0;
            cmd_refused_o <= acc_erase && prot_hit;
            unique case (er_reg)
                ER_IDLE: begin
                    if (acc_erase && !prot_hit) begin
                        er_reg <= ER_RUN;
                        remain_reg <= erase_cyc;
                        region_o <= '{kind: kind, first: first, last: last};
                    end
                end
                ER_RUN: begin
                    if (acc_susp) begin
                        er_reg <= ER_SUSPENDING;
                        sus_cnt_reg <= 16'(`SUSPEND_CYC);
                    end else if (remain_reg <= 32'h0000_0001) begin
                        er_reg <= ER_IDLE;
                        erase_done_o <= 1'b1;
                    end else begin
                        remain_reg <= remain_reg - 32'h0000_0001;
                    end
                end
                ER_SUSPENDING: begin
                    // Busy stays up until the array reaches a safe stop
                    if (sus_cnt_reg <= 16'h0001) begin
                        er_reg <= ER_SUSPENDED;
                    end else begin
                        sus_cnt_reg <= sus_cnt_reg - 16'h0001;
                    end
                end
                ER_SUSPENDED: begin
                    if (acc_res) begin
                        er_reg <= ER_RUN;
                    end
                end
            endcase
        end
    end

    // Write-enable latch; completion wins since set needs an idle part
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wel_reg <= 1'b0;
        end else if (er_reg == ER_RUN && !acc_susp && remain_reg <= 32'h0000_0001) begin
            wel_reg <= 1'b0;
        end else if (acc_wren) begin
            wel_reg <= 1'b1;
        end else if (acc_wrdi) begin
            wel_reg <= 1'b0;
        end
    end

    // Suspend flag follows the command at once, ahead of busy
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sus_reg <= 1'b0;
        end else if (acc_susp) begin
            sus_reg <= 1'b1;
        end else if (acc_res) begin
            sus_reg <= 1'b0;
        end
    end

    // Power mode; commands are dropped during entry and release windows
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pm_reg <= PM_NORMAL;
            pm_cnt_reg <= 16'h0000;
        end else begin
            unique case (pm_reg)
                PM_NORMAL: begin
                    if (acc_pd) begin
                        pm_reg <= PM_ENTER;
                        pm_cnt_reg <= 16'(`POWERDOWN_ENTRY_CYC);
                    end
                end
                PM_ENTER: begin
                    if (pm_cnt_reg <= 16'h0001) begin
                        pm_reg <= PM_DOWN;
                    end else begin
                        pm_cnt_reg <= pm_cnt_reg - 16'h0001;
                    end
                end
                PM_DOWN: begin
                    if (acc_rel) begin
                        pm_reg <= PM_EXIT;
                        pm_cnt_reg <= 16'(`POWERDOWN_RELEASE_CYC);
                    end
                end
                PM_EXIT: begin
                    if (pm_cnt_reg <= 16'h0001) begin
                        pm_reg <= PM_NORMAL;
                    end else begin
                        pm_cnt_reg <= pm_cnt_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign stat_core.busy = busy;
    assign stat_core.write_enable_latch = wel_reg;
    assign stat_core.suspend_flag = sus_reg;
    assign stat_core.powerdown = (pm_reg != PM_NORMAL);
    assign status_o = stat_core;
    assign erase_active_o = (er_reg == ER_RUN);
endmodule

`default_nettype wire

// File: test/flash_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module flash_seq_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic spi_do_oe_o,
    input wire flash_seq_pkg::status_t status_o,
    input wire flash_seq_pkg::erase_region_t region_o,
    input wire logic erase_active_o,
    input wire logic erase_done_o,
    input wire logic cmd_refused_o
);
    import flash_seq_pkg::*;
    localparam int SUS_MAX = 1010;
    logic [10:0] sus_cnt_reg;
    logic [19:0] span;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    assign span = (region_o.kind == EK_SECTOR) ? 20'h00fff : (region_o.kind == EK_BLOCK32) ? 20'h07fff :
        (region_o.kind == EK_BLOCK64) ? 20'h0ffff : 20'hfffff;
    // Width leaves room above SUS_MAX so an overrun shows before wrapping
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sus_cnt_reg <= 11'h000;
        end else if (status_o.suspend_flag && status_o.busy) begin
            sus_cnt_reg <= sus_cnt_reg + 11'h001;
        end else begin
            sus_cnt_reg <= 11'h000;
        end
    end
    sequence s_suspend_start;
        $rose(status_o.suspend_flag);
    endsequence
    sequence s_quiet3;
        (!status_o.busy && !erase_active_o)[*3];
    endsequence
    sequence s_idle_unlatched;
        !status_o.busy && !status_o.write_enable_latch;
    endsequence
    a_done_clears_wel: assert property (erase_done_o |-> ##[0:1] s_idle_unlatched)
        else $error("erase end left busy or latch set");
    a_active_is_busy: assert property (erase_active_o |-> status_o.busy && !status_o.suspend_flag)
        else $error("active erase not shown as busy");
    a_suspend_needs_run: assert property (
        s_suspend_start |-> $past(erase_active_o) && region_o.kind != EK_CHIP)
        else $error("suspend taken without a suspendable erase");
    a_suspend_latency: assert property (sus_cnt_reg <= SUS_MAX)
        else $error("busy held too long after suspend");
    a_resume_busy: assert property ($fell(status_o.suspend_flag) |-> ##[0:9] status_o.busy)
        else $error("busy not back within 200 ns of resume");
    a_start_needs_wel: assert property (
        $rose(status_o.busy) && !$past(status_o.suspend_flag) |-> status_o.write_enable_latch)
        else $error("erase started without write enable");
    a_refused_stays_idle: assert property (cmd_refused_o |-> s_quiet3)
        else $error("refused erase still started");
    a_pd_silent: assert property (status_o.powerdown |-> !spi_do_oe_o && !erase_active_o)
        else $error("output driven in power-down");
    a_region_span: assert property (
        erase_active_o |-> ((region_o.first & span) == 20'h0) && ((region_o.first | span) == region_o.last))
        else $error("erase region not an aligned unit");
endmodule
bind flash_erase_seq flash_seq_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .spi_do_oe_o(spi_do_oe_o),
    .status_o(status_o), .region_o(region_o), .erase_active_o(erase_active_o),
    .erase_done_o(erase_done_o), .cmd_refused_o(cmd_refused_o));
`default_nettype wire

// File: test/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic spi_clk_o,
    output logic spi_cs_n_o,
    output logic spi_di_o,
    input wire logic spi_do_i,
    input wire logic spi_do_oe_i
);
    initial begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_di_o = 1'b0;
    end
    // Clock idles low and only runs inside a frame, 48 ns period
    task automatic xfer(input logic [31:0] w, input int n, input int nrd, output logic [7:0] rd,
        output logic oe);
        int i;
        rd = 8'h00;
        oe = 1'b0;
        spi_cs_n_o = 1'b0;
        for (i = 0; i < n + nrd; i++) begin
            if (i < n)
                spi_di_o = w[n - 1 - i];
            #24 spi_clk_o = 1'b1;
            if (i >= n) begin
                // An undriven data line must not pass for the last driven bit
                rd = {rd[6:0], spi_do_oe_i ? spi_do_i : ~spi_do_i};
                oe = oe | spi_do_oe_i;
            end
            #24 spi_clk_o = 1'b0;
        end
        #24 spi_cs_n_o = 1'b1;
        // Released data line must not keep its last value
        spi_di_o = ~spi_di_o;
        // Chip select stays high long enough for the core to decode the frame
        #200;
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_seq_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe;
    protect_t protect_i = '0;
    status_t status_o;
    erase_region_t region_o, last_region;
    logic erase_active_o, erase_done_o, cmd_refused_o;
    logic [42:0] exp_q[$];
    logic [31:0] seed = 32'h262a;
    logic [19:0] a;
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    logic [19:0] masks [5] = '{20'h00fff, 20'h07fff, 20'h0ffff, 20'hfffff, 20'hfffff};
    erase_kind_t kinds [5] = '{EK_SECTOR, EK_BLOCK32, EK_BLOCK64, EK_CHIP, EK_CHIP};
    int miscompares = 0;
    int check_count = 0;
    int k;
    always #10 mclk_i = ~mclk_i;
    // Short erase times keep the run brief; suspend latency stays at its default
    flash_erase_seq #(.SECTOR_ERASE_CYC(120), .BLOCK32_ERASE_CYC(130), .BLOCK64_ERASE_CYC(400),
        .CHIP_ERASE_CYC(300)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
        .spi_cs_n_i(spi_cs_n), .spi_di_i(spi_di), .spi_do_o(spi_do), .spi_do_oe_o(spi_do_oe),
        .protect_i(protect_i), .status_o(status_o), .region_o(region_o),
        .erase_active_o(erase_active_o), .erase_done_o(erase_done_o), .cmd_refused_o(cmd_refused_o));
    spi_host_model host_u (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_di_o(spi_di),
        .spi_do_i(spi_do), .spi_do_oe_i(spi_do_oe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [31:0] w, input int n);
        logic [7:0] b;
        logic o;
        host_u.xfer(w, n, 0, b, o);
    endtask
    task automatic rdsr(input logic [7:0] op, input logic [7:0] eb, input logic eo);
        logic [7:0] b;
        logic o;
        host_u.xfer({24'h0, op}, 8, 8, b, o);
        chk(o, eo);
        if (eo)
            chk(b, eb);
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 3000 && status_o.busy !== 1'b0; i++)
            @(negedge mclk_i);
        chk(status_o.busy, 1'b0);
    endtask
    task give_verdict;
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(negedge mclk_i) begin
        if (erase_done_o === 1'b1 || cmd_refused_o === 1'b1)
            chk({cmd_refused_o, region_o}, exp_q.size() != 0 ? exp_q.pop_front() : '1);
    end
    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i) rst_i = 1'b0;
        chk(status_o, 4'h0);
        repeat (3) @(negedge mclk_i);
        cmd({8'h20, 24'h012345}, 32);
        chk(status_o.busy, 1'b0);
        for (k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            a = seed[19:0];
            cmd(32'h06, 8);
            chk(status_o.write_enable_latch, 1'b1);
            last_region = '{kinds[k], a & ~masks[k], a | masks[k]};
            exp_q.push_back({1'b0, last_region});
            cmd((k < 3) ? {ops[k], 4'h0, a} : {24'h0, ops[k]}, (k < 3) ? 32 : 8);
            rdsr(8'h05, 8'h03, 1'b1);
            chk(erase_active_o, 1'b1);
            if (k == 3) begin
                cmd(32'h75, 8);
                chk(status_o.suspend_flag, 1'b0);
            end
            // While suspended only status reads and resume go out
            if (k == 2) begin
                cmd(32'h75, 8);
                chk({status_o.suspend_flag, erase_active_o}, 2'b10);
                repeat (1100) @(negedge mclk_i);
                chk(status_o.busy, 1'b0);
                rdsr(8'h35, 8'h80, 1'b1);
                cmd(32'h7a, 8);
                chk({status_o.suspend_flag, status_o.busy}, 2'b01);
                // No suspend may follow a resume before the suspend latency is over
                repeat (1000) @(negedge mclk_i);
            end
            wait_idle();
            chk(status_o.write_enable_latch, 1'b0);
        end
        cmd(32'h75, 8);
        cmd(32'h7a, 8);
        chk({status_o.suspend_flag, status_o.busy}, 2'b00);
        repeat (1000) @(negedge mclk_i);
        cmd(32'h06, 8);
        cmd(32'h10009000, 31);
        chk(status_o.busy, 1'b0);
        @(negedge mclk_i) protect_i = 6'b000001;
        exp_q.push_back({1'b1, last_region});
        cmd({8'h20, 24'h0f5000}, 32);
        chk(status_o.busy, 1'b0);
        exp_q.push_back({1'b1, last_region});
        cmd(32'hc7, 8);
        chk(status_o.busy, 1'b0);
        @(negedge mclk_i) protect_i = 6'b000000;
        cmd(32'h06, 8);
        cmd(32'h172, 9);
        chk(status_o.powerdown, 1'b0);
        cmd(32'hb9, 8);
        chk(status_o.powerdown, 1'b1);
        repeat (200) @(negedge mclk_i);
        rdsr(8'h05, 8'h00, 1'b0);
        cmd(32'h04, 8);
        chk(status_o.write_enable_latch, 1'b1);
        cmd(32'hab, 8);
        repeat (200) @(negedge mclk_i);
        chk(status_o.powerdown, 1'b0);
        rdsr(8'h05, 8'h02, 1'b1);
        cmd({8'hd8, 24'h040000}, 32);
        cmd(32'h75, 8);
        chk({status_o.suspend_flag, erase_active_o}, 2'b10);
        @(negedge mclk_i) rst_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        chk(status_o, 4'h0);
        repeat (3) @(negedge mclk_i);
        cmd(32'h7a, 8);
        chk(status_o, 4'h0);
        chk(exp_q.size(), 0);
        give_verdict();
    end
endmodule
`default_nettype wire
